/* crcu_ahb_master.sv */
// bus master model: pipelined ahb-lite transfers toward the checksum unit
`timescale 1ns/1ps
module crcu_ahb_master (
	input wire logic core_clk, // bus clock
	input wire logic [31:0] hrdata, // read data
	input wire logic hready, // slave ready, low stalls both phases
	output logic hsel, // select
	output logic [31:0] haddr, // address
	output logic [1:0] htrans, // transfer type
	output logic hwrite, // write
	output logic [2:0] hsize, // size, word unless an op asks otherwise
	output logic [31:0] hwdata // write data
);
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [2:0] s;
	} crcu_op_t;
	crcu_op_t ops[$];
	logic [31:0] rds[$];
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// address of op k overlaps the data phase of op k-1; idle address and unused write data lines get inverted so stale values never match
	task automatic run();
		int n;
		n = ops.size();
		for (int k = 0; k <= n; k++)
		begin
			@(negedge core_clk);
			if (k > 0 && !ops[k-1].w)
				rds.push_back(hrdata);
			hwdata <= (k > 0 && ops[k-1].w) ? ops[k-1].d : ~hwdata;
			hsel <= k < n;
			htrans <= (k < n) ? 2'h2 : 2'h0;
			hwrite <= (k < n) ? ops[k].w : 1'b0;
			hsize <= (k < n) ? ops[k].s : 3'h2;
			haddr <= (k < n) ? {24'h0, ops[k].a} : ~haddr;
			// both phases hold until the slave is ready again
			do
				@(posedge core_clk);
			while (!hready);
		end
		ops.delete();
	endtask
endmodule

/* crcu_parallel.sv */
// one-clock parallel crc step, msb-first, any crc and data width
`timescale 1ns/1ps
module crcu_parallel #(
	parameter int CW = 32,
	parameter int DW = 32,
	parameter logic [CW-1:0] POLY = '0
) (
	input wire logic [CW-1:0] crcIn, // previous result
	input wire logic [DW-1:0] dataIn, // data, first bit in msb
	output logic [CW-1:0] crcOut // new result
);
	logic [CW-1:0] stage [0:DW];

	assign stage[0] = crcIn;

	// one shift-and-reduce stage per data bit, all unrolled into one cycle
	genvar i;
	generate
		for (i = 0; i < DW; i++)
		begin : gStep
			wire fb = stage[i][CW-1] ^ dataIn[DW-1-i];
			assign stage[i+1] = {stage[i][CW-2:0], 1'b0} ^ (fb ? POLY : '0);
		end
	endgenerate

	assign crcOut = stage[DW];
endmodule

/* crcu_pkg.sv */
// constants, register map and carrier types of the crc32/crc16/lrc checksum unit
// Summary of operation
// - CRC32 uses fixed 32-bit generator polynomial
// - CRC16 takes bytes, polynomial x16+x15+x2+1
// - every calculation finishes in one clock
// - each word write folds into previous result
// - reading data register returns current result
// - back-to-back writes and write-read stay correct
// - reinitialise loads CRC32 result with ones
// - reinitialise bit acts on one, self-clears
// - reinitialise leaves scratch byte untouched
// - scratch byte is plain storage, no CRC
// - CRC16 bit order follows order select
// - clear bit or zero write clears CRC16
// - result write seeds next CRC16, else chains
// - LRC runs alongside CRC16, both readable
// - LRC check value is eight bits wide
// - CRC16 clear is one-cycle, reads zero
// - order 0 feeds MSB first, 1 LSB first
// - each input byte write updates CRC16 result
// - input bytes XOR into LRC; software clears it
package crcu_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register offsets, low eight address bits
	localparam logic [7:0] CRCU_OFF_CRC32_DATA = 8'h00;
	localparam logic [7:0] CRCU_OFF_SCRATCH = 8'h04;
	localparam logic [7:0] CRCU_OFF_CRC32_CTRL = 8'h08;
	localparam logic [7:0] CRCU_OFF_CRC16_CTRL = 8'h0c;
	localparam logic [7:0] CRCU_OFF_CRC16_IN = 8'h10;
	localparam logic [7:0] CRCU_OFF_CRC16_RES = 8'h14;
	localparam logic [7:0] CRCU_OFF_LRC = 8'h18;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CRCU_BIT_REINIT = 0;
	localparam int CRCU_BIT_ORDER = 1;
	localparam int CRCU_BIT_CLEAR = 2;

	////////////////////////////////////////////////////////////////////////////
	// reset values and polynomials
	localparam logic [31:0] CRCU_RST_CRC32 = 32'hffffffff;
	localparam logic [7:0] CRCU_RST_BYTE = 8'h00;
	localparam logic [15:0] CRCU_RST_CRC16 = 16'h0000;
	localparam logic [31:0] CRCU_POLY32 = 32'h04c11db7;
	localparam logic [15:0] CRCU_POLY16 = 16'h8005;

	////////////////////////////////////////////////////////////////////////////
	// bus encodings
	localparam logic [2:0] CRCU_SIZE_BYTE = 3'h0;
	localparam logic [2:0] CRCU_SIZE_HALF = 3'h1;
	localparam logic [3:0] CRCU_LANES_ALL = 4'hf;

	// data phase of a write, captured in the address phase
	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [3:0] lanes;
	} crcu_acc_t;

endpackage

/* crcu_top.sv */
// checksum unit: ahb slave, crc32 engine with scratch byte, crc16 engine with lrc
`timescale 1ns/1ps
module crcu_top (
	input wire logic core_clk, // system bus clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic clkEn, // freezes all state while low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address, low eight bits decoded
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data, data phase
	input wire logic hready, // bus ready in
	output logic [31:0] hrdata, // read data, registered
	output logic hreadyout, // slave ready
	output logic hresp // always okay
);

	////////////////////////////////////////////////////////////////////////////
	// state

	crcu_pkg::crcu_acc_t accQ;
	crcu_pkg::crcu_acc_t accD;
	logic [31:0] crc32Q;
	logic [31:0] crc32D;
	logic [7:0] scratchQ;
	logic [7:0] scratchD;
	logic orderQ;
	logic orderD;
	logic [7:0] inByteQ;
	logic [7:0] inByteD;
	logic [15:0] crc16Q;
	logic [15:0] crc16_result_init;
	logic [7:0] lrcQ;
	logic [7:0] lrcD;
	logic [31:0] hrdataQ;
	logic [31:0] hrdataD;

	////////////////////////////////////////////////////////////////////////////
	// byte-lane selection from size and the two low address bits

	function automatic logic [3:0] laneSel(input logic [2:0] size, input logic [1:0] a);
		logic [3:0] m;
		m = crcu_pkg::CRCU_LANES_ALL;
		if (size == crcu_pkg::CRCU_SIZE_BYTE)
		begin
			m = 4'h1 << a;
		end
		else if (size == crcu_pkg::CRCU_SIZE_HALF)
		begin
			m = a[1] ? 4'hc : 4'h3;
		end
		return m;
	endfunction

	// replace only the enabled byte lanes of a word
	function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] lanes);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (lanes[b])
			begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// address phase

	// zero wait states: the slave stalls the bus only while frozen
	assign hreadyout = clkEn;
	assign hresp = 1'b0;

	wire addrValid = hsel & htrans[1] & hready;
	wire rdReq = addrValid & ~hwrite;
	// registers are word wide: the two low address bits only pick byte lanes, so 0x15 reaches the result high byte
	wire [7:0] rdAddr = {haddr[7:2], 2'b00};

	always_comb
	begin
		accD.write = addrValid & hwrite;
		accD.addr = {haddr[7:2], 2'b00};
		accD.lanes = laneSel(hsize, haddr[1:0]);
	end

	////////////////////////////////////////////////////////////////////////////
	// data phase write decode

	wire hitData = accQ.write && accQ.addr == crcu_pkg::CRCU_OFF_CRC32_DATA;
	wire hitScratch = accQ.write && accQ.addr == crcu_pkg::CRCU_OFF_SCRATCH;
	wire hitCtrl32 = accQ.write && accQ.addr == crcu_pkg::CRCU_OFF_CRC32_CTRL;
	wire hitCtrl16 = accQ.write && accQ.addr == crcu_pkg::CRCU_OFF_CRC16_CTRL;
	wire hitIn = accQ.write && accQ.addr == crcu_pkg::CRCU_OFF_CRC16_IN;
	wire hitRes = accQ.write && accQ.addr == crcu_pkg::CRCU_OFF_CRC16_RES;
	wire hitLrc = accQ.write && accQ.addr == crcu_pkg::CRCU_OFF_LRC;

	// the crc32 word must arrive whole; narrower writes are dropped
	wire wr32 = hitData && accQ.lanes == crcu_pkg::CRCU_LANES_ALL;
	// only a one written acts; the bit itself is never stored, so it is clear again at once
	wire reinit = hitCtrl32 && accQ.lanes[0] && hwdata[crcu_pkg::CRCU_BIT_REINIT];
	wire clear16 = hitCtrl16 && accQ.lanes[0] && hwdata[crcu_pkg::CRCU_BIT_CLEAR];
	wire feed = hitIn && accQ.lanes[0];

	////////////////////////////////////////////////////////////////////////////
	// engines

	logic [31:0] crc32Calc;
	logic [15:0] crc16Calc;

	crcu_parallel #(
		.CW(32),
		.DW(32),
		.POLY(crcu_pkg::CRCU_POLY32)
	) uCrc32 (
		.crcIn(crc32Q),
		.dataIn(hwdata),
		.crcOut(crc32Calc)
	);

	// reversing the byte turns the msb-first engine into an lsb-first one
	wire [7:0] revByte = {<<{hwdata[7:0]}};
	wire [7:0] byte16 = orderQ ? revByte : hwdata[7:0];

	crcu_parallel #(
		.CW(16),
		.DW(8),
		.POLY(crcu_pkg::CRCU_POLY16)
	) uCrc16 (
		.crcIn(crc16Q),
		.dataIn(byte16),
		.crcOut(crc16Calc)
	);

	////////////////////////////////////////////////////////////////////////////
	// next-state selection

	assign crc32D = reinit ? crcu_pkg::CRCU_RST_CRC32 : wr32 ? crc32Calc : crc32Q;
	assign scratchD = (hitScratch && accQ.lanes[0]) ? hwdata[7:0] : scratchQ;
	assign orderD = (hitCtrl16 && accQ.lanes[0]) ? hwdata[crcu_pkg::CRCU_BIT_ORDER] : orderQ;
	assign inByteD = feed ? hwdata[7:0] : inByteQ;

	// a zero written to the result clears it just as the clear bit does
	wire [31:0] resMerged = mergeLanes({16'h0000, crc16Q}, hwdata, accQ.lanes);
	assign crc16_result_init = clear16 ? crcu_pkg::CRCU_RST_CRC16 :
		feed ? crc16Calc :
		hitRes ? resMerged[15:0] :
		crc16Q;

	// lrc folds every input byte as it arrives, in the same cycle as the crc16
	assign lrcD = feed ? (lrcQ ^ hwdata[7:0]) :
		(hitLrc && accQ.lanes[0]) ? hwdata[7:0] :
		lrcQ;

	////////////////////////////////////////////////////////////////////////////
	// read mux: built from next values so a read right after a write sees the new result

	wire [31:0] rdData32 = crc32D;
	wire [31:0] rdScratch = {24'h000000, scratchD};
	wire [31:0] rdCtrl16 = {29'h0, 1'b0, orderD, 1'b0};
	wire [31:0] rdIn = {24'h000000, inByteD};
	wire [31:0] rdRes = {16'h0000, crc16_result_init};
	wire [31:0] rdLrc = {24'h000000, lrcD};

	always_comb
	begin
		hrdataD = 32'h00000000;
		if (rdReq)
		begin
			case (rdAddr)
				crcu_pkg::CRCU_OFF_CRC32_DATA: hrdataD = rdData32;
				crcu_pkg::CRCU_OFF_SCRATCH: hrdataD = rdScratch;
				crcu_pkg::CRCU_OFF_CRC16_CTRL: hrdataD = rdCtrl16;
				crcu_pkg::CRCU_OFF_CRC16_IN: hrdataD = rdIn;
				crcu_pkg::CRCU_OFF_CRC16_RES: hrdataD = rdRes;
				crcu_pkg::CRCU_OFF_LRC: hrdataD = rdLrc;
				default: hrdataD = 32'h00000000;
			endcase
		end
	end

	assign hrdata = hrdataQ;

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			accQ <= '0;
			hrdataQ <= 32'h00000000;
		end
		else if (clkEn)
		begin
			accQ <= accD;
			hrdataQ <= hrdataD;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			crc32Q <= crcu_pkg::CRCU_RST_CRC32;
			scratchQ <= crcu_pkg::CRCU_RST_BYTE;
		end
		else if (clkEn)
		begin
			crc32Q <= crc32D;
			scratchQ <= scratchD;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			orderQ <= 1'b0;
			inByteQ <= crcu_pkg::CRCU_RST_BYTE;
			crc16Q <= crcu_pkg::CRCU_RST_CRC16;
			lrcQ <= crcu_pkg::CRCU_RST_BYTE;
		end
		else if (clkEn)
		begin
			orderQ <= orderD;
			inByteQ <= inByteD;
			crc16Q <= crc16_result_init;
			lrcQ <= lrcD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	reinit_load_a: assert property (
		clkEn && reinit |=> crc32Q == 32'hffffffff && !$past(wr32))
		else $error("crc32 not reloaded with ones");

	scratch_kept_a: assert property (
		clkEn && reinit |=> scratchQ == $past(scratchQ))
		else $error("scratch byte changed by reinit");

	crc32_step_a: assert property (
		clkEn && wr32 |=> crc32Q == $past(crc32Calc))
		else $error("crc32 not folded from previous result");

	read_fresh_a: assert property (
		clkEn && rdReq && rdAddr == crcu_pkg::CRCU_OFF_CRC32_DATA |=> hrdata == crc32Q)
		else $error("crc32 read returned stale value");

	ctrl_zero_a: assert property (
		clkEn && rdReq && rdAddr == crcu_pkg::CRCU_OFF_CRC32_CTRL |=> hrdata == 32'h0)
		else $error("crc32 control read not zero");

	clear_read_a: assert property (
		clkEn && rdReq && rdAddr == crcu_pkg::CRCU_OFF_CRC16_CTRL |=> hrdata[2] == 1'b0 && hrdata[31:3] == 29'h0)
		else $error("crc16 clear bit read back as one");

	clear_crc16_a: assert property (
		clkEn && clear16 |=> crc16Q == 16'h0000)
		else $error("crc16 not cleared");

	lrc_xor_a: assert property (
		clkEn && feed |=> lrcQ == ($past(lrcQ) ^ $past(hwdata[7:0])) && crc16Q == $past(crc16Calc))
		else $error("lrc and crc16 not updated together");

	order_lsb_a: assert property (
		clkEn && feed && orderQ |-> byte16 == {hwdata[0], hwdata[1], hwdata[2], hwdata[3],
			hwdata[4], hwdata[5], hwdata[6], hwdata[7]})
		else $error("lsb-first order not applied");

	reserved_zero_a: assert property (
		clkEn && rdReq && (rdAddr == crcu_pkg::CRCU_OFF_LRC || rdAddr == crcu_pkg::CRCU_OFF_SCRATCH)
		|=> hrdata[31:8] == 24'h000000)
		else $error("reserved bits read as nonzero");

	freeze_a: assert property (
		!clkEn |=> $stable(crc32Q) && $stable(crc16Q) && $stable(lrcQ))
		else $error("state moved while clock enable low");

endmodule

/* test_crcu_top.sv */
// self-checking bench for the checksum unit: register sequences with computed expectations
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("Error at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module test_crcu_top;
	logic core_clk, rst_n, clkEn, hsel, hwrite, hresp, hreadyout;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, e32;
	logic [15:0] e16;
	logic [7:0] eLrc;
	logic [31:0] expQ[$];
	int mismatches = 0;
	int comparisons = 0;
	crcu_top DUT (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	crcu_ahb_master MST (.core_clk(core_clk), .hrdata(hrdata), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	////////////////////////////////////////////////////////////////////////////
	// reference models, written independently of the engine
	function automatic logic [31:0] c32(input logic [31:0] c, input logic [31:0] d);
		for (int i = 31; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? crcu_pkg::CRCU_POLY32 : 32'h0);
		return c;
	endfunction
	function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] b, input logic o);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ (o ? b[7-i] : b[i])) ? crcu_pkg::CRCU_POLY16 : 16'h0);
		return c;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	task automatic wrn(input logic [7:0] a, input logic [31:0] d, input logic [2:0] s);
		MST.ops.push_back({1'b1, a, d, s});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wrn(a, d, 3'h2);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		MST.ops.push_back({1'b0, a, 32'h0, 3'h2});
		expQ.push_back(e);
	endtask
	// a nonzero stall freezes the unit for three cycles mid-sequence; results must come out the same
	task automatic go(input string name, input int stall = 0);
		fork
			MST.run();
			if (stall > 0)
			begin
				repeat (stall) @(negedge core_clk);
				clkEn = 1'b0;
				repeat (3) @(negedge core_clk);
				`CHK(hreadyout, 1'b0)
				clkEn = 1'b1;
			end
		join
		foreach (expQ[i])
			`CHK(MST.rds[i], expQ[i])
		`CHK(hresp, 1'b0)
		`CHK(hreadyout, 1'b1)
		expQ.delete();
		MST.rds.delete();
		$display("test %s done", name);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// whole run is under a hundred cycles
	initial
	begin
		repeat (3000) @(posedge core_clk);
		mismatches++;
		$display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		final_report();
	end
	initial
	begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		rd(8'h00, 32'hffffffff);
		for (int a = 4; a <= 8'h1c; a += 4)
			rd(8'(a), 32'h0);
		rd(8'h40, 32'h0);
		go("reset");
		e32 = c32(c32(32'hffffffff, 32'h12345678), 32'h80000001);
		wr(8'h00, 32'h12345678);
		wr(8'h00, 32'h80000001);
		rd(8'h00, e32);
		wrn(8'h00, 32'h0, crcu_pkg::CRCU_SIZE_HALF);
		rd(8'h00, e32);
		wr(8'h08, 32'hfffffffe);
		rd(8'h00, e32);
		rd(8'h08, 32'h0);
		wr(8'h04, 32'h123456a5);
		wr(8'h08, 32'h1);
		rd(8'h00, 32'hffffffff);
		rd(8'h08, 32'h0);
		rd(8'h04, 32'ha5);
		wrn(8'h14, 32'h000000cd, crcu_pkg::CRCU_SIZE_BYTE);
		wrn(8'h15, 32'h0000ab00, crcu_pkg::CRCU_SIZE_BYTE);
		rd(8'h14, 32'h0000abcd);
		go("crc32", 3);
		for (int o = 0; o < 2; o++)
		begin
			eLrc = 8'h3c ^ 8'h31 ^ 8'h80;
			e16 = c16(c16(16'h1d0f, 8'h31, o[0]), 8'h80, o[0]);
			wr(8'h18, 32'h3c);
			wr(8'h14, 32'h1d0f);
			wr(8'h0c, 32'(o) << 1);
			wr(8'h10, 32'hffffff31);
			wr(8'h10, 32'h80);
			rd(8'h14, 32'(e16));
			rd(8'h18, 32'(eLrc));
			rd(8'h0c, 32'(o) << 1);
			rd(8'h10, 32'h80);
			wr(8'h10, 32'h5a);
			rd(8'h14, 32'(c16(e16, 8'h5a, o[0])));
			wr(8'h0c, 32'h4 | (32'(o) << 1));
			rd(8'h14, 32'h0);
			rd(8'h0c, 32'(o) << 1);
			wr(8'h14, 32'h1234);
			wr(8'h14, 32'h0);
			rd(8'h14, 32'h0);
			wr(8'h18, 32'h0);
			rd(8'h18, 32'h0);
			go("crc16 and lrc");
		end
		final_report();
	end
endmodule
